/* adc_host_model.sv */
// Host side of the serial link for the converter bench
`timescale 1ns/1ns
`default_nettype none
module adc_host_model (
  output logic sclk,
  output logic din,
  input wire logic dout
);
  initial begin
    sclk = 1'b0;
    din = 1'b0;
  end
  // Frame of n bits, MSB first, sclk still between frames
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = 32'h0;
    for (int i = n - 1; i >= 0; i--) begin
      din = tx[i];
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
      rx = {rx[30:0], dout};
    end
    din = ~din;
  endtask
endmodule
`default_nettype wire

/* adc_mode_control.sv */
// Mode register, conversion sequencing and serial register access of the converter
// How it works
// - Top two mode bits pick conversion mode
// - Continuous mode converts back to back
// - Ready goes low when result stored
// - Continuous read shifts each result out
// - First continuous result after two periods
// - Later results once per period
// - Single mode powered down when idle
// - Single conversion: two periods, store, sleep
// - Single result and ready held until read
// - Burnout bit switches test currents
// - Burnout only effective while buffered
// - Unipolar coding: zero in, zero out
// - Bipolar coding: negative full scale zero
// - Buffer bit selects buffered input
// - Mode register select 01, reset 02
// - Mode write resets filter, ready high
`timescale 1ns/1ns
`default_nettype none
`include "adc_params.svh"

module adc_mode_control
  import adc_pkg::*;
#(
  parameter int unsigned CONV_CYC = 32'(`CONV_CYC_DEF)
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic din,
  input wire logic [23:0] sample,
  output logic dout,
  output logic rdy_n,
  output logic mod_power_up,
  output logic burnout_current_enable,
  output logic buffer_en,
  output logic mod_reset
);

  localparam logic [31:0] PERIOD_LAST = 32'(CONV_CYC - 1);
  localparam logic [31:0] SETTLE_LAST = 32'(`SETTLE_PERIODS * CONV_CYC - 1);

  localparam core_t CORE_RESET = '{
    mode: `MODE_RESET,
    st: ST_SETTLE,
    timer: SETTLE_LAST,
    data: 24'h000000,
    shadow_d: 24'h000000,
    shadow_m: `MODE_RESET,
    rdy_n: 1'b1,
    pwr_up: 1'b1,
    burnout: 1'b0,
    buf_en: 1'b1,
    mod_rst: 1'b0,
    wr_s: 3'h0,
    rd_s: 3'h0,
    busy_s: 2'h0
  };

  localparam link_t LINK_RESET = '{
    phase: PH_COMM,
    cnt: 5'h00,
    sh: 24'h000000,
    rs: `RS_COMM,
    cread: 1'b0,
    reading: 1'b0,
    wr_tgl: 1'b0,
    rd_tgl: 1'b0,
    wr_byte: 8'h00,
    dout: 1'b0
  };

  core_t c_r;
  core_t c_nxt;
  link_t l_r;
  link_t l_nxt;
  logic wr_evt;
  logic rd_evt;
  logic store;
  conv_mode_t md;
  conv_mode_t md_new;
  logic [7:0] cmd;

  // Output coding of the modulator's two's complement result
  function automatic logic [23:0] code(input logic [23:0] s, input logic unip);
    if (unip) begin
      code = s[23] ? 24'h000000 : {s[22:0], s[22]};
    end else begin
      code = {~s[23], s[22:0]};
    end
  endfunction

  // Word placed on the serial output for a register read
  function automatic logic [23:0] frame(input logic [1:0] rs, input logic [23:0] d,
                                        input logic [7:0] m, input logic r);
    logic [7:0] st_b;
    st_b = `STATUS_FIXED;
    st_b[`RDY_BIT] = r;
    unique case (rs)
      `RS_DATA: frame = d;
      `RS_MODE: frame = {m, 16'h0000};
      default: frame = {st_b, 16'h0000};
    endcase
  endfunction

  // Conversion sequencing in the core clock domain
  always_comb begin
    c_nxt = c_r;
    c_nxt.wr_s = {c_r.wr_s[1:0], l_r.wr_tgl};
    c_nxt.rd_s = {c_r.rd_s[1:0], l_r.rd_tgl};
    c_nxt.busy_s = {c_r.busy_s[0], l_r.reading};
    wr_evt = c_r.wr_s[2] ^ c_r.wr_s[1];
    rd_evt = c_r.rd_s[2] ^ c_r.rd_s[1];
    md = conv_mode_t'(c_r.mode[`MODE_FLD_HI:`MODE_FLD_LO]);
    md_new = conv_mode_t'(l_r.wr_byte[`MODE_FLD_HI:`MODE_FLD_LO]);
    store = 1'b0;
    c_nxt.mod_rst = 1'b0;
    if (c_r.timer != 32'h0) begin
      c_nxt.timer = c_r.timer - 32'h1;
    end
    unique case (c_r.st)
      ST_OFF: begin
      end
      ST_SETTLE, ST_RUN: begin
        if (c_r.timer == 32'h0) begin
          store = 1'b1;
          if (md == MD_SINGLE) begin
            c_nxt.st = ST_OFF;
          end else begin
            c_nxt.st = ST_RUN;
            c_nxt.timer = PERIOD_LAST;
          end
        end
      end
      default: begin
        c_nxt.st = ST_OFF;
      end
    endcase
    if (store) begin
      c_nxt.data = code(sample, c_r.mode[`UB_BIT]);
      c_nxt.rdy_n = 1'b0;
    end else if (rd_evt) begin
      c_nxt.rdy_n = 1'b1;
    end
    if (wr_evt) begin
      c_nxt.mode = l_r.wr_byte;
      c_nxt.mod_rst = 1'b1;
      c_nxt.rdy_n = 1'b1;
      c_nxt.timer = SETTLE_LAST;
      if (md_new == MD_CONT || md_new == MD_SINGLE) begin
        c_nxt.st = ST_SETTLE;
      end else begin
        c_nxt.st = ST_OFF;
      end
    end
    c_nxt.pwr_up = (c_nxt.st != ST_OFF);
    c_nxt.burnout = c_nxt.mode[`BO_BIT] & c_nxt.mode[`BUF_BIT];
    c_nxt.buf_en = c_nxt.mode[`BUF_BIT];
    // Shadow takes the new result in the cycle ready falls, unless a read is in progress, then once it ends
    if (!c_r.busy_s[1]) begin
      c_nxt.shadow_d = c_nxt.data;
      c_nxt.shadow_m = c_nxt.mode;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      c_r <= CORE_RESET;
    end else begin
      c_r <= c_nxt;
    end
  end

  // Serial link logic on the host's serial clock
  always_comb begin
    l_nxt = l_r;
    l_nxt.sh = {l_r.sh[22:0], din};
    l_nxt.cnt = l_r.cnt + 5'h01;
    cmd = {l_r.sh[6:0], din};
    unique case (l_r.phase)
      PH_COMM: begin
        if (l_r.cnt == `BYTE_LAST) begin
          l_nxt.cnt = 5'h00;
          l_nxt.rs = cmd[`CMD_RS_HI:`CMD_RS_LO];
          if (cmd[`CMD_RD_BIT]) begin
            {l_nxt.dout, l_nxt.sh} = {frame(cmd[`CMD_RS_HI:`CMD_RS_LO], c_r.shadow_d,
                                            c_r.shadow_m, c_r.rdy_n), 1'b0};
            l_nxt.phase = PH_RDATA;
            l_nxt.reading = 1'b1;
            l_nxt.cread = cmd[`CMD_CREAD_BIT] &&
                          (cmd[`CMD_RS_HI:`CMD_RS_LO] == `RS_DATA);
          end else if (cmd[`CMD_RS_HI:`CMD_RS_LO] == `RS_MODE) begin
            l_nxt.phase = PH_WDATA;
          end
        end
      end
      PH_WDATA: begin
        if (l_r.cnt == `BYTE_LAST) begin
          l_nxt.cnt = 5'h00;
          l_nxt.wr_byte = cmd;
          l_nxt.wr_tgl = ~l_r.wr_tgl;
          l_nxt.phase = PH_COMM;
        end
      end
      PH_RDATA: begin
        l_nxt.dout = l_r.sh[23];
        l_nxt.sh = {l_r.sh[22:0], 1'b0};
        if (l_r.cnt == ((l_r.rs == `RS_DATA) ? `WORD_LAST : `BYTE_LAST)) begin
          l_nxt.cnt = 5'h00;
          l_nxt.reading = 1'b0;
          l_nxt.dout = 1'b0;
          if (l_r.rs == `RS_DATA) begin
            l_nxt.rd_tgl = ~l_r.rd_tgl;
          end
          l_nxt.phase = l_r.cread ? PH_CWAIT : PH_COMM;
        end
      end
      PH_CWAIT: begin
        {l_nxt.dout, l_nxt.sh} = {c_r.shadow_d, 1'b0};
        l_nxt.cnt = 5'h00;
        l_nxt.reading = 1'b1;
        l_nxt.phase = PH_RDATA;
      end
      default: begin
        l_nxt.phase = PH_COMM;
      end
    endcase
  end

  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      l_r <= LINK_RESET;
    end else begin
      l_r <= l_nxt;
    end
  end

  assign dout = l_r.dout;
  assign rdy_n = c_r.rdy_n;
  assign mod_power_up = c_r.pwr_up;
  assign burnout_current_enable = c_r.burnout;
  assign buffer_en = c_r.buf_en;
  assign mod_reset = c_r.mod_rst;

  // Checks on the core domain
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  property p_wr_ready;
    wr_evt |=> rdy_n && mod_reset;
  endproperty
  a_wr_ready: assert property (p_wr_ready) else $error("ready not high after mode write");

  property p_store_ready;
    store && !wr_evt |=> !rdy_n ##1 (!rdy_n || $past(rd_evt) || $past(wr_evt));
  endproperty
  a_store_ready: assert property (p_store_ready) else $error("ready not low after result");

  property p_period;
    store && !wr_evt && md == MD_CONT |=> c_r.timer == PERIOD_LAST && c_r.st == ST_RUN;
  endproperty
  a_period: assert property (p_period) else $error("next result not one period away");

  property p_settle;
    wr_evt && (md_new == MD_CONT || md_new == MD_SINGLE)
      |=> c_r.timer == SETTLE_LAST && mod_power_up;
  endproperty
  a_settle: assert property (p_settle) else $error("settling not two periods");

  property p_single_sleep;
    store && !wr_evt && md == MD_SINGLE |=> !mod_power_up && !rdy_n;
  endproperty
  a_single_sleep: assert property (p_single_sleep) else $error("single not back to sleep");

  property p_single_hold;
    c_r.st == ST_OFF && !rdy_n && !rd_evt && !wr_evt |=> !rdy_n;
  endproperty
  a_single_hold: assert property (p_single_hold) else $error("single result ready dropped");

  property p_pdown;
    wr_evt && md_new == MD_PDOWN |=> !mod_power_up [*3];
  endproperty
  a_pdown: assert property (p_pdown) else $error("power down not held");

  property p_burnout;
    burnout_current_enable |-> c_r.mode[`BO_BIT] && buffer_en;
  endproperty
  a_burnout: assert property (p_burnout) else $error("burnout without buffer");

  property p_buffer;
    buffer_en == c_r.mode[`BUF_BIT];
  endproperty
  a_buffer: assert property (p_buffer) else $error("buffer does not follow its bit");

  property p_unipolar;
    store && !wr_evt && c_r.mode[`UB_BIT] && !sample[23]
      |=> c_r.data == {$past(sample[22:0]), $past(sample[22])};
  endproperty
  a_unipolar: assert property (p_unipolar) else $error("unipolar code wrong");

  property p_bipolar;
    store && !wr_evt && !c_r.mode[`UB_BIT] && sample == 24'h800000
      |=> c_r.data == 24'h000000;
  endproperty
  a_bipolar: assert property (p_bipolar) else $error("bipolar negative full scale wrong");

  property p_mode_take;
    wr_evt |=> c_r.mode == $past(l_r.wr_byte);
  endproperty
  a_mode_take: assert property (p_mode_take) else $error("mode byte not taken");

  property p_read_clear;
    rd_evt && !store && !wr_evt |=> rdy_n;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("ready not high after read");

  property p_burnout_off;
    !c_r.mode[`BO_BIT] |-> !burnout_current_enable;
  endproperty
  a_burnout_off: assert property (p_burnout_off) else $error("burnout on with bit clear");

  property p_reset_pulse;
    mod_reset |=> !mod_reset;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("filter reset not one pulse");

  property p_cont_run;
    store && !wr_evt && md == MD_CONT |=> mod_power_up;
  endproperty
  a_cont_run: assert property (p_cont_run) else $error("continuous mode stopped");

  property p_pdown_ready;
    wr_evt && md_new == MD_PDOWN |=> rdy_n [*3];
  endproperty
  a_pdown_ready: assert property (p_pdown_ready) else $error("ready low in power down");

  c_single: cover property (store && md == MD_SINGLE);
  c_cont_twice: cover property (store && md == MD_CONT && c_r.st == ST_RUN);
  c_read_done: cover property (rd_evt && !rdy_n);
  c_mode_write: cover property (wr_evt && md_new == MD_PDOWN);

endmodule
`default_nettype wire

/* adc_mode_control_tb_top.sv */
// Self-checking bench of the converter mode control
`timescale 1ns/1ns
`default_nettype none
module adc_mode_control_tb_top;
  localparam int C = 64;
  logic clk = 1'b0;
  logic resetn = 1'b1;
  logic [23:0] sample = 24'h800000;
  wire logic sclk, din, dout, rdy_n, pwr, bo, buf_en, mrst;
  int fail_count = 0;
  int samples_checked = 0;
  logic [31:0] rx;
  int n;
  time t1;
  always #25 clk = ~clk;
  adc_mode_control #(.CONV_CYC(C)) u_dut (.clk(clk), .resetn(resetn), .sclk(sclk),
    .din(din), .sample(sample), .dout(dout), .rdy_n(rdy_n), .mod_power_up(pwr),
    .burnout_current_enable(bo), .buffer_en(buf_en), .mod_reset(mrst));
  adc_host_model u_host (.sclk(sclk), .din(din), .dout(dout));
  task automatic report_and_stop();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(inout int cnt, input int lim);
    @(posedge clk);
    #1;
    cnt++;
    if (cnt > lim) begin
      fail_count++;
      $display("ERROR %0t wait timed out", $time);
      report_and_stop();
    end
  endtask
  task automatic wait_rdy(input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (rdy_n !== lvl) tick(cnt, lim);
  endtask
  task automatic hold_chk(input int k, input logic r, input logic p);
    int i;
    i = 0;
    repeat (k) begin
      tick(i, k);
      chk(24'({rdy_n, pwr}), 24'({r, p}));
    end
  endtask
  task automatic wr_mode(input logic [7:0] v);
    int i;
    u_host.xfer(16, {16'h0, 8'h10, v}, rx);
    i = 0;
    while (mrst !== 1'b1) tick(i, 10);
    chk(24'(rdy_n), 24'h1);
    tick(i, 20);
    chk(24'(mrst), 24'h0);
  endtask
  task automatic rd_data(input logic [23:0] exp);
    u_host.xfer(32, {8'h70, 24'h0}, rx);
    chk(rx[24:1], exp);
  endtask
  task automatic s_power_on();
    chk(24'({rdy_n, pwr, bo, buf_en}), 24'hd);
    wait_rdy(1'b0, 3 * C, n);
    chk(24'(n >= 2 * C && n <= 2 * C + 2), 24'h1);
    t1 = $time;
    rd_data(24'h000000);
    wait_rdy(1'b1, 10, n);
    wait_rdy(1'b0, C, n);
    chk(24'(($time - t1) / 50), 24'(C));
    u_host.xfer(16, {16'h0, 8'h50, 8'h0}, rx);
    chk(24'(rx[8:1]), 24'h02);
  endtask
  task automatic s_single();
    sample = 24'h000000;
    wr_mode(8'h84);
    chk(24'(pwr), 24'h1);
    wait_rdy(1'b0, 3 * C, n);
    chk(24'(n >= 2 * C - 2 && n <= 2 * C), 24'h1);
    repeat (2) tick(n, 4 * C);
    hold_chk(2 * C, 1'b0, 1'b0);
    rd_data(24'h000000);
    wait_rdy(1'b1, 10, n);
    hold_chk(2 * C + 4, 1'b1, 1'b0);
  endtask
  task automatic s_off();
    logic [7:0] modes [2];
    modes = '{8'hc0, 8'hc2};
    foreach (modes[i]) begin
      wr_mode(modes[i]);
      repeat (2) tick(n, 4 * C);
      hold_chk(3 * C, 1'b1, 1'b0);
    end
  endtask
  task automatic s_bits();
    logic [7:0] v [4];
    v = '{8'h0a, 8'h08, 8'h02, 8'h00};
    foreach (v[i]) begin
      wr_mode(v[i]);
      chk(24'({bo, buf_en}), 24'({v[i][3] & v[i][1], v[i][1]}));
      u_host.xfer(16, {16'h0, 8'h50, 8'h0}, rx);
      chk(24'(rx[8:1]), 24'(v[i]));
    end
  endtask
  task automatic s_cread();
    sample = 24'h000000;
    wr_mode(8'h00);
    wait_rdy(1'b0, 3 * C, n);
    u_host.xfer(32, {8'h74, 24'h0}, rx);
    chk(rx[24:1], 24'h800000);
    tick(n, 4 * C);
    sample = 24'h7fffff;
    wait_rdy(1'b1, 10, n);
    wait_rdy(1'b0, 2 * C, n);
    u_host.xfer(25, 32'h0, rx);
    chk(rx[24:1], 24'hffffff);
  endtask
  initial begin
    #1 resetn = 1'b0;
    repeat (20) @(posedge clk);
    #1 resetn = 1'b1;
    s_power_on();
    s_single();
    s_off();
    s_bits();
    s_cread();
    report_and_stop();
  end
endmodule
`default_nettype wire

/* adc_params.svh */
// Offsets, field positions, reset values and timing counts of the converter control
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH
`define RS_COMM 2'h0
`define RS_MODE 2'h1
`define RS_FILT 2'h2
`define RS_DATA 2'h3
`define MODE_RESET 8'h02
`define MODE_FLD_HI 7
`define MODE_FLD_LO 6
`define BO_BIT 3
`define UB_BIT 2
`define BUF_BIT 1
`define CMD_RD_BIT 6
`define CMD_RS_HI 5
`define CMD_RS_LO 4
`define CMD_CREAD_BIT 2
`define STATUS_FIXED 8'h0c
`define RDY_BIT 7
`define CLK_HZ 20000000
`define OUT_RATE_MHZ 16600
`define CONV_CYC_DEF ((64'd`CLK_HZ * 64'd1000) / 64'd`OUT_RATE_MHZ)
`define SETTLE_PERIODS 2
`define BYTE_LAST 5'h07
`define WORD_LAST 5'h17
`endif

/* adc_pkg.sv */
// Types shared by the converter control
package adc_pkg;
  typedef enum logic [1:0] {MD_CONT, MD_RSVD, MD_SINGLE, MD_PDOWN} conv_mode_t;
  typedef enum logic [1:0] {ST_OFF, ST_SETTLE, ST_RUN} conv_state_t;
  typedef enum logic [1:0] {PH_COMM, PH_WDATA, PH_RDATA, PH_CWAIT} link_phase_t;
  typedef struct packed {
    logic [7:0] mode;
    conv_state_t st;
    logic [31:0] timer;
    logic [23:0] data;
    logic [23:0] shadow_d;
    logic [7:0] shadow_m;
    logic rdy_n;
    logic pwr_up;
    logic burnout;
    logic buf_en;
    logic mod_rst;
    logic [2:0] wr_s;
    logic [2:0] rd_s;
    logic [1:0] busy_s;
  } core_t;
  typedef struct packed {
    link_phase_t phase;
    logic [4:0] cnt;
    logic [23:0] sh;
    logic [1:0] rs;
    logic cread;
    logic reading;
    logic wr_tgl;
    logic rd_tgl;
    logic [7:0] wr_byte;
    logic dout;
  } link_t;
endpackage
